// ### rtl/dih_line_regen.v
// Purpose: measures and regenerates horizontal sync width and back porch for one port
// Assumes: hs_in and de_in come from logic on core_clk, active high
// Notes:   the value measured on one line steers the next line
`timescale 1ns/100ps
module dih_line_regen #(
    parameter W = 10
) (
    core_clk,
    sys_rst,
    ce,
    dual_en,
    hs_in,
    de_in,
    bp_ov_en,
    bp_ov_val,
    sw_ov_en,
    sw_ov_val,
    hs_out_r,
    bp_out_r,
    act_start_r,
    meas_bp_r,
    meas_sw_r
);
    input  wire         core_clk;
    input  wire         sys_rst;
    input  wire         ce;
    input  wire         dual_en;
    input  wire         hs_in;
    input  wire         de_in;
    input  wire         bp_ov_en;
    input  wire [W-1:0] bp_ov_val;
    input  wire         sw_ov_en;
    input  wire [W-1:0] sw_ov_val;
    output reg          hs_out_r;
    output reg          bp_out_r;
    output reg          act_start_r;
    output reg  [W-1:0] meas_bp_r;
    output reg  [W-1:0] meas_sw_r;

    localparam M_IDLE  = 2'd0;
    localparam M_SYNC  = 2'd1;
    localparam M_PORCH = 2'd2;
    localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
    localparam [W-1:0] MAX = {W{1'b1}};

    reg         hs_d_r;
    reg         de_d_r;
    reg [1:0]   mst_r;
    reg [W-1:0] mcnt_r;
    reg [1:0]   gst_r;
    reg [W-1:0] gcnt_r;
    reg [W-1:0] gsw_r;
    reg [W-1:0] gbp_r;
    wire        hs_rise = hs_in & ~hs_d_r;
    wire        hs_fall = ~hs_in & hs_d_r;
    wire        de_rise = de_in & ~de_d_r;
    // chosen source, clamped to one cycle so a zero never stalls the line
    wire [W-1:0] sw_sel = sw_ov_en ? sw_ov_val : meas_sw_r;
    wire [W-1:0] bp_sel = bp_ov_en ? bp_ov_val : meas_bp_r;
    wire [W-1:0] sw_use = (sw_sel == {W{1'b0}}) ? ONE : sw_sel;
    wire [W-1:0] bp_use = (bp_sel == {W{1'b0}}) ? ONE : bp_sel;
    wire [W-1:0] mcnt_inc = (mcnt_r == MAX) ? MAX : mcnt_r + ONE;

    // measure sync width and back porch of the incoming line
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hs_d_r    <= 1'b0;
            de_d_r    <= 1'b0;
            mst_r     <= M_IDLE;
            mcnt_r    <= {W{1'b0}};
            meas_bp_r <= {W{1'b0}};
            meas_sw_r <= {W{1'b0}};
        end else if (ce) begin
            hs_d_r <= hs_in;
            de_d_r <= de_in;
            if (hs_rise) begin
                mst_r  <= M_SYNC;
                mcnt_r <= ONE;
            end else begin
                case (mst_r)
                    M_SYNC: begin
                        if (hs_fall) begin
                            meas_sw_r <= mcnt_r;
                            mst_r     <= M_PORCH;
                            mcnt_r    <= ONE;
                        end else begin
                            mcnt_r <= mcnt_inc;
                        end
                    end
                    M_PORCH: begin
                        if (de_rise) begin
                            meas_bp_r <= mcnt_r;
                            mst_r     <= M_IDLE;
                        end else begin
                            mcnt_r <= mcnt_inc;
                        end
                    end
                    default: mst_r <= M_IDLE;
                endcase
            end
        end
    end

    // regenerate the line; settings are taken only at the sync edge
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gst_r       <= M_IDLE;
            gcnt_r      <= {W{1'b0}};
            gsw_r       <= ONE;
            gbp_r       <= ONE;
            hs_out_r    <= 1'b0;
            bp_out_r    <= 1'b0;
            act_start_r <= 1'b0;
        end else if (ce) begin
            act_start_r <= 1'b0;
            if (!dual_en) begin
                // plain path: pass timing through one flop stage
                gst_r       <= M_IDLE;
                hs_out_r    <= hs_in;
                bp_out_r    <= 1'b0;
                act_start_r <= de_rise;
            end else if (hs_rise) begin
                gsw_r    <= sw_use;
                gbp_r    <= bp_use;
                gst_r    <= M_SYNC;
                gcnt_r   <= ONE;
                hs_out_r <= 1'b1;
                bp_out_r <= 1'b0;
            end else begin
                case (gst_r)
                    M_SYNC: begin
                        if (gcnt_r >= gsw_r) begin
                            hs_out_r <= 1'b0;
                            bp_out_r <= 1'b1;
                            gst_r    <= M_PORCH;
                            gcnt_r   <= ONE;
                        end else begin
                            gcnt_r <= gcnt_r + ONE;
                        end
                    end
                    M_PORCH: begin
                        if (gcnt_r >= gbp_r) begin
                            bp_out_r    <= 1'b0;
                            act_start_r <= 1'b1;
                            gst_r       <= M_IDLE;
                        end else begin
                            gcnt_r <= gcnt_r + ONE;
                        end
                    end
                    default: begin
                        hs_out_r <= 1'b0;
                        bp_out_r <= 1'b0;
                        gst_r    <= M_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// ### rtl/dih_map.vh
// Purpose: register indexes, field positions, reset values of the sync override block
// Assumes: register index is the printed offset, byte address is four times the index
// Notes:   included by its bare name
`ifndef DIH_MAP_VH
`define DIH_MAP_VH

// register indexes (byte address = index * 4)
`define DIH_IDX_ENABLES      10'h06a
`define DIH_IDX_LOW_WIDTH    10'h06b
`define DIH_IDX_LOW_PORCH    10'h06c
`define DIH_IDX_MODE         10'h070
`define DIH_IDX_STATUS       10'h071

// enables register fields
`define DIH_BIT_BP_EN        7
`define DIH_BIT_BP_HI_MSB    5
`define DIH_BIT_BP_HI_LSB    4
`define DIH_BIT_SW_EN        3
`define DIH_BIT_SW_HI_MSB    1
`define DIH_BIT_SW_HI_LSB    0

// mode register fields
`define DIH_BIT_DUAL_EN      0
`define DIH_BIT_INDEP        1
`define DIH_BIT_PORT_SEL     2

// status register fields
`define DIH_STAT_BP_LSB      0
`define DIH_STAT_SW_LSB      16

// reset values
`define DIH_RST_ENABLE       1'b0
`define DIH_RST_VALUE        10'h000
`define DIH_RST_MODE         3'h0

`endif

// ### rtl/dih_sync_override.v
// Purpose: APB register front end and two-port sync timing regeneration for dual-image video
// Assumes: core_clk is the pixel clock, video timing inputs are on the same clock
// Notes:   one extra wait state on every APB access; ce low freezes everything
//          status register is read-only, writes to it complete without error
//          10-bit values span two registers; a split update may mix for one line
//          video inputs are on core_clk already, so they pass no synchroniser
`timescale 1ns/100ps
`include "dih_map.vh"
module dih_sync_override (
    core_clk,
    sys_rst,
    ce,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    p0_hs_in,
    p0_de_in,
    p1_hs_in,
    p1_de_in,
    p0_hs_out,
    p0_bp_out,
    p0_act_start,
    p1_hs_out,
    p1_bp_out,
    p1_act_start
);
    input  wire        core_clk;
    input  wire        sys_rst;
    input  wire        ce;
    input  wire        psel;
    input  wire        penable;
    input  wire        pwrite;
    input  wire [11:0] paddr;
    input  wire [31:0] pwdata;
    output wire [31:0] prdata;
    output wire        pready;
    output wire        pslverr;
    input  wire        p0_hs_in;
    input  wire        p0_de_in;
    input  wire        p1_hs_in;
    input  wire        p1_de_in;
    output wire        p0_hs_out;
    output wire        p0_bp_out;
    output wire        p0_act_start;
    output wire        p1_hs_out;
    output wire        p1_bp_out;
    output wire        p1_act_start;

    // port 0 override fields
    reg        back_porch_override_enable_r;
    reg [9:0]  back_porch_override_value_r;
    reg        sync_width_override_enable_r;
    reg [9:0]  sync_width_override_value_r;

    // port 1 override fields
    reg        back_porch_override_enable_port1_r;
    reg [9:0]  back_porch_override_value_port1_r;
    reg        sync_width_override_enable_port1_r;
    reg [9:0]  sync_width_override_value_port1_r;

    // mode: dual-image enable, independent/splitter, selected port
    reg [2:0]  mode_r;

    // bus answer, registered so the bus sees clean flop outputs
    reg [31:0] prdata_r;
    reg        pready_r;
    reg        pslverr_r;
    // next read word and decode hit, from the read mux
    reg [31:0] rd_nxt;
    reg        hit_nxt;

    // measured timing of each port, seen through the status register
    wire [9:0] p0_meas_bp;
    wire [9:0] p0_meas_sw;
    wire [9:0] p1_meas_bp;
    wire [9:0] p1_meas_sw;

    // word index; the two byte-lane bits of paddr are ignored
    wire [9:0] idx       = paddr[11:2];
    wire       dual_en   = mode_r[`DIH_BIT_DUAL_EN];
    wire       indep     = mode_r[`DIH_BIT_INDEP];
    wire       port_sel  = mode_r[`DIH_BIT_PORT_SEL];

    // outside independent mode both ports share one setting, so writes mirror
    wire       tgt_p0    = ~indep | ~port_sel;
    wire       tgt_p1    = ~indep | port_sel;
    wire       rd_p1     = indep & port_sel;

    // write lands only on the completing access edge
    // pslverr blocks the write, so a bad index never aliases a register
    wire       acc_done  = psel & penable & pready_r;
    wire       wr_stb    = acc_done & pwrite & ~pslverr_r;
    wire       wr_en     = wr_stb & (idx == `DIH_IDX_ENABLES);
    wire       wr_lw     = wr_stb & (idx == `DIH_IDX_LOW_WIDTH);
    wire       wr_lp     = wr_stb & (idx == `DIH_IDX_LOW_PORCH);
    wire       wr_mode   = wr_stb & (idx == `DIH_IDX_MODE);

    // selected field set, seen by reads
    // outside independent mode this is port 0; port 1 fields written apart in independent mode stay unseen
    wire       sel_bp_en = rd_p1 ? back_porch_override_enable_port1_r
                                 : back_porch_override_enable_r;
    wire [9:0] sel_bp    = rd_p1 ? back_porch_override_value_port1_r
                                 : back_porch_override_value_r;
    wire       sel_sw_en = rd_p1 ? sync_width_override_enable_port1_r
                                 : sync_width_override_enable_r;
    wire [9:0] sel_sw    = rd_p1 ? sync_width_override_value_port1_r
                                 : sync_width_override_value_r;

    // measured timing of the same port, for the status word
    wire [9:0] sel_mbp   = rd_p1 ? p1_meas_bp : p0_meas_bp;
    wire [9:0] sel_msw   = rd_p1 ? p1_meas_sw : p0_meas_sw;

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // read mux and address decode; reserved bits read as zero
    // the mux reaches the bus only through prdata_r, so it may glitch freely
    always @* begin
        rd_nxt  = 32'h00000000;
        hit_nxt = 1'b1;
        case (idx)
            // enables and the high bits of both override values
            `DIH_IDX_ENABLES: begin
                rd_nxt[`DIH_BIT_BP_EN] = sel_bp_en;
                rd_nxt[`DIH_BIT_BP_HI_MSB:`DIH_BIT_BP_HI_LSB] = sel_bp[9:8];
                rd_nxt[`DIH_BIT_SW_EN] = sel_sw_en;
                rd_nxt[`DIH_BIT_SW_HI_MSB:`DIH_BIT_SW_HI_LSB] = sel_sw[9:8];
            end
            // low byte of the sync-width override
            `DIH_IDX_LOW_WIDTH: begin
                rd_nxt[7:0] = sel_sw[7:0];
            end
            // low byte of the back-porch override
            `DIH_IDX_LOW_PORCH: begin
                rd_nxt[7:0] = sel_bp[7:0];
            end
            // mode bits read back as written
            `DIH_IDX_MODE: begin
                rd_nxt[2:0] = mode_r;
            end
            // measured timing, read-only
            `DIH_IDX_STATUS: begin
                rd_nxt[`DIH_STAT_BP_LSB+9:`DIH_STAT_BP_LSB] = sel_mbp;
                rd_nxt[`DIH_STAT_SW_LSB+9:`DIH_STAT_SW_LSB] = sel_msw;
            end
            // anything else is refused with pslverr
            default: begin
                hit_nxt = 1'b0;
            end
        endcase
    end

    // answer one cycle into the access phase, dropped after the completing edge
    // the wait cycle gives the read mux a full cycle from the address
    // ce low stretches the wait, since the answer flops freeze too
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (ce) begin
            if (psel & penable & ~pready_r) begin
                pready_r  <= 1'b1;
                pslverr_r <= ~hit_nxt;
                prdata_r  <= (pwrite | ~hit_nxt) ? 32'h00000000 : rd_nxt;
            end else begin
                pready_r  <= 1'b0;
                pslverr_r <= 1'b0;
                // read data stands for the answer cycle only
                prdata_r  <= 32'h00000000;
            end
        end
    end

    // mode register
    // dual off passes timing straight through; the port select only
    // matters once the independent bit is set
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_r <= `DIH_RST_MODE;
        end else if (ce && wr_mode) begin
            mode_r <= pwdata[2:0];
        end
    end

    // port 0 override fields
    // high bits and low byte land separately; the regenerator samples them
    // only at a sync edge, so update both parts within one line
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            back_porch_override_enable_r <= `DIH_RST_ENABLE;
            back_porch_override_value_r  <= `DIH_RST_VALUE;
            sync_width_override_enable_r <= `DIH_RST_ENABLE;
            sync_width_override_value_r  <= `DIH_RST_VALUE;
        end else if (ce && tgt_p0) begin
            if (wr_en) begin
                back_porch_override_enable_r     <= pwdata[`DIH_BIT_BP_EN];
                back_porch_override_value_r[9:8] <=
                    pwdata[`DIH_BIT_BP_HI_MSB:`DIH_BIT_BP_HI_LSB];
                sync_width_override_enable_r     <= pwdata[`DIH_BIT_SW_EN];
                sync_width_override_value_r[9:8] <=
                    pwdata[`DIH_BIT_SW_HI_MSB:`DIH_BIT_SW_HI_LSB];
            end
            // low bytes, each in its own register
            if (wr_lw) begin
                sync_width_override_value_r[7:0] <= pwdata[7:0];
            end
            if (wr_lp) begin
                back_porch_override_value_r[7:0] <= pwdata[7:0];
            end
        end
    end

    // port 1 override fields, a separate set reached through the port select
    // written together with port 0 unless independent mode picks one
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            back_porch_override_enable_port1_r <= `DIH_RST_ENABLE;
            back_porch_override_value_port1_r  <= `DIH_RST_VALUE;
            sync_width_override_enable_port1_r <= `DIH_RST_ENABLE;
            sync_width_override_value_port1_r  <= `DIH_RST_VALUE;
        end else if (ce && tgt_p1) begin
            if (wr_en) begin
                back_porch_override_enable_port1_r     <= pwdata[`DIH_BIT_BP_EN];
                back_porch_override_value_port1_r[9:8] <=
                    pwdata[`DIH_BIT_BP_HI_MSB:`DIH_BIT_BP_HI_LSB];
                sync_width_override_enable_port1_r     <= pwdata[`DIH_BIT_SW_EN];
                sync_width_override_value_port1_r[9:8] <=
                    pwdata[`DIH_BIT_SW_HI_MSB:`DIH_BIT_SW_HI_LSB];
            end
            // low bytes, each in its own register
            if (wr_lw) begin
                sync_width_override_value_port1_r[7:0] <= pwdata[7:0];
            end
            if (wr_lp) begin
                back_porch_override_value_port1_r[7:0] <= pwdata[7:0];
            end
        end
    end

    // port 0 timing path
    // both paths share dual_en; a mode change acts at once, the overrides
    // only at each port's next sync edge
    dih_line_regen #(
        .W (10)
    ) u_port0 (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .ce          (ce),
        .dual_en     (dual_en),
        .hs_in       (p0_hs_in),
        .de_in       (p0_de_in),
        .bp_ov_en    (back_porch_override_enable_r),
        .bp_ov_val   (back_porch_override_value_r),
        .sw_ov_en    (sync_width_override_enable_r),
        .sw_ov_val   (sync_width_override_value_r),
        .hs_out_r    (p0_hs_out),
        .bp_out_r    (p0_bp_out),
        .act_start_r (p0_act_start),
        .meas_bp_r   (p0_meas_bp),
        .meas_sw_r   (p0_meas_sw)
    );

    // port 1 timing path
    // same regenerator, fed from the port 1 field set
    dih_line_regen #(
        .W (10)
    ) u_port1 (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .ce          (ce),
        .dual_en     (dual_en),
        .hs_in       (p1_hs_in),
        .de_in       (p1_de_in),
        .bp_ov_en    (back_porch_override_enable_port1_r),
        .bp_ov_val   (back_porch_override_value_port1_r),
        .sw_ov_en    (sync_width_override_enable_port1_r),
        .sw_ov_val   (sync_width_override_value_port1_r),
        .hs_out_r    (p1_hs_out),
        .bp_out_r    (p1_bp_out),
        .act_start_r (p1_act_start),
        .meas_bp_r   (p1_meas_bp),
        .meas_sw_r   (p1_meas_sw)
    );
endmodule

// ### test/dih_sync_override_monitor.sv
// Purpose: port-level checks of the dual-image sync override block
// Assumes: ce held high, so the bus answer has a fixed wait
// Notes:   bound to every instance of the top module
`timescale 1ns/100ps
module dih_sync_override_monitor (
    input logic        core_clk,
    input logic        sys_rst,
    input logic        psel,
    input logic        penable,
    input logic        pready,
    input logic        pslverr,
    input logic [31:0] prdata,
    input logic        p0_hs_in,
    input logic        p0_hs_out,
    input logic        p0_bp_out,
    input logic        p0_act_start,
    input logic        p1_hs_out,
    input logic        p1_bp_out,
    input logic        p1_act_start
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // first access cycle of a transfer
    sequence s_access_start;
        psel && $rose(penable);
    endsequence
    // back porch ends while no new sync restarted the line
    sequence s_bp0_end;
        $fell(p0_bp_out) && !p0_hs_out;
    endsequence

    // bus answer: one wait state, one-cycle strobes
    chk_ready_wait: assert property (s_access_start |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    // regenerated timing order: sync, porch, active start
    chk_bp_follow0: assert property ($rose(p0_bp_out) |-> $past(p0_hs_out))
        else $error("port 0 porch not after sync");
    chk_bp_follow1: assert property ($rose(p1_bp_out) |-> $past(p1_hs_out))
        else $error("port 1 porch not after sync");
    chk_act_after_bp: assert property (s_bp0_end |-> p0_act_start)
        else $error("active start missing after porch");
    chk_act_pulse: assert property (p1_act_start |=> !p1_act_start)
        else $error("active start longer than one cycle");
    chk_hs_cause: assert property ($rose(p0_hs_out) |-> $past(p0_hs_in))
        else $error("sync out without sync in");
    chk_no_overlap: assert property (!(p1_hs_out && p1_bp_out))
        else $error("sync and porch overlap");
endmodule

bind dih_sync_override dih_sync_override_monitor mon_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .p0_hs_in(p0_hs_in),
    .p0_hs_out(p0_hs_out), .p0_bp_out(p0_bp_out), .p0_act_start(p0_act_start),
    .p1_hs_out(p1_hs_out), .p1_bp_out(p1_bp_out), .p1_act_start(p1_act_start)
);

// ### test/dih_sync_override_test.sv
// Purpose: self-checking bench of the dual-image sync override block
// Assumes: ce held high, both ports fed the same input timing
// Notes:   reads and pulse widths are compared with notes kept in queues
`timescale 1ns/100ps
`include "dih_map.vh"
`define CHK(got, exp) begin \
    num_checks = num_checks + 1; \
    if ((got) !== (exp)) begin \
        n_fail = n_fail + 1; \
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module dih_sync_override_test;
    reg          core_clk, sys_rst, ce, psel, penable, pwrite;
    reg  [11:0]  paddr;
    reg  [31:0]  pwdata;
    reg          hs_in, de_in;
    wire [31:0]  prdata;
    wire         pready, pslverr;
    wire [1:0]   hs_o, bp_o, act_o;
    integer      n_fail, num_checks;
    integer      cyc = 0;
    logic [32:0] q_rd[$];
    logic [32:0] e_rd;
    logic [10:0] q_w[2][$];
    logic [10:0] q_b[2][$];
    logic [10:0] cnt_w[2] = '{11'h0, 11'h0};
    logic [10:0] cnt_b[2] = '{11'h0, 11'h0};
    logic [10:0] e_v;
    logic [7:0]  r1, r2;

    dih_sync_override dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .p0_hs_in(hs_in), .p0_de_in(de_in), .p1_hs_in(hs_in),
        .p1_de_in(de_in), .p0_hs_out(hs_o[0]), .p0_bp_out(bp_o[0]),
        .p0_act_start(act_o[0]), .p1_hs_out(hs_o[1]), .p1_bp_out(bp_o[1]),
        .p1_act_start(act_o[1])
    );

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task give_verdict;
        begin
            if (n_fail == 0 && num_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // timeout guard, then read and pulse-width watchers
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            n_fail = n_fail + 1;
            give_verdict();
        end
        if (psel && penable && pready && !pwrite && q_rd.size() > 0) begin
            e_rd = q_rd.pop_front();
            `CHK({pslverr, prdata}, e_rd)
        end
        for (int p = 0; p < 2; p++) begin
            if (hs_o[p] === 1'b1)
                cnt_w[p] = cnt_w[p] + 1;
            else if (cnt_w[p] != 0) begin
                if (q_w[p].size() > 0) begin
                    e_v = q_w[p].pop_front();
                    `CHK(cnt_w[p], e_v)
                end
                cnt_w[p] = 0;
            end
            if (bp_o[p] === 1'b1)
                cnt_b[p] = cnt_b[p] + 1;
            else if (cnt_b[p] != 0) begin
                if (q_b[p].size() > 0) begin
                    e_v = q_b[p].pop_front();
                    `CHK(cnt_b[p], e_v)
                end
                cnt_b[p] = 0;
            end
        end
    end

    // one transfer, held until pready; a read leaves its expected answer
    task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
             input logic [32:0] exp);
        begin
            @(posedge core_clk);
            psel    <= 1'b1;
            pwrite  <= wr;
            paddr   <= {idx, 2'b00};
            pwdata  <= wd;
            if (!wr)
                q_rd.push_back(exp);
            @(posedge core_clk);
            penable <= 1'b1;
            do @(posedge core_clk); while (pready !== 1'b1);
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task wr(input logic [9:0] idx, input logic [31:0] wd);
        apb(1'b1, idx, wd, 33'h0);
    endtask

    task rd(input logic [9:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0, {1'b0, exp});
    endtask

    // one input line; tail long enough for the longest regenerated timing
    task line(input logic [10:0] win, bin, w0, b0, w1, b1, input logic chk);
        begin
            if (chk) begin
                q_w[0].push_back(w0);
                q_b[0].push_back(b0);
                q_w[1].push_back(w1);
                q_b[1].push_back(b1);
            end
            @(posedge core_clk);
            hs_in <= 1'b1;
            repeat (win) @(posedge core_clk);
            hs_in <= 1'b0;
            repeat (bin) @(posedge core_clk);
            de_in <= 1'b1;
            repeat (20) @(posedge core_clk);
            de_in <= 1'b0;
            repeat (1400) @(posedge core_clk);
        end
    endtask

    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        hs_in = 1'b0;
        de_in = 1'b0;
        n_fail = 0;
        num_checks = 0;
        r1 = $urandom(32'h8c4a0d3f);
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        // reset values, an unmapped index, reserved bits
        rd(`DIH_IDX_ENABLES, 32'h0);
        rd(`DIH_IDX_LOW_WIDTH, 32'h0);
        rd(`DIH_IDX_LOW_PORCH, 32'h0);
        apb(1'b0, 10'h06d, 32'h0, {1'b1, 32'h0});
        wr(`DIH_IDX_ENABLES, 32'hff);
        rd(`DIH_IDX_ENABLES, 32'hbb);
        wr(`DIH_IDX_ENABLES, 32'h0);
        // pass-through line first, watched by the port checks only
        line(12, 9, 0, 0, 0, 0, 1'b0);
        // measured timing steers the next line
        wr(`DIH_IDX_MODE, 32'h1);
        line(12, 9, 0, 0, 0, 0, 1'b0);
        line(12, 9, 12, 9, 12, 9, 1'b1);
        rd(`DIH_IDX_STATUS, {16'd12, 16'd9});
        // both overrides with high bits set
        r1 = $urandom;
        r2 = $urandom;
        wr(`DIH_IDX_LOW_WIDTH, {24'h0, r1});
        wr(`DIH_IDX_LOW_PORCH, {24'h0, r2});
        wr(`DIH_IDX_ENABLES, 32'ha9);
        rd(`DIH_IDX_LOW_WIDTH, {24'h0, r1});
        rd(`DIH_IDX_LOW_PORCH, {24'h0, r2});
        line(12, 9, {3'h1, r1}, {3'h2, r2}, {3'h1, r1}, {3'h2, r2}, 1'b1);
        // porch override alone, width measured again
        wr(`DIH_IDX_ENABLES, 32'ha0);
        line(12, 9, 12, {3'h2, r2}, 12, {3'h2, r2}, 1'b1);
        // independent mode: port 1 gets its own fields
        wr(`DIH_IDX_MODE, 32'h7);
        wr(`DIH_IDX_ENABLES, 32'h08);
        wr(`DIH_IDX_LOW_WIDTH, 32'h5);
        rd(`DIH_IDX_ENABLES, 32'h08);
        wr(`DIH_IDX_MODE, 32'h3);
        rd(`DIH_IDX_ENABLES, 32'ha0);
        rd(`DIH_IDX_LOW_WIDTH, {24'h0, r1});
        line(12, 9, 12, {3'h2, r2}, 5, 9, 1'b1);
        // shared mode again, porch set to twice the 2D porch of 9
        wr(`DIH_IDX_MODE, 32'h1);
        wr(`DIH_IDX_LOW_PORCH, 32'h12);
        wr(`DIH_IDX_ENABLES, 32'h80);
        line(12, 9, 12, 18, 12, 18, 1'b1);
        // every noted read and pulse must have been seen
        `CHK(q_rd.size() + q_w[0].size() + q_w[1].size(), 0)
        `CHK(q_b[0].size() + q_b[1].size(), 0)
        give_verdict();
    end
endmodule
